/* bte_engine.sv */
// Purpose: Block transfer engine of the controller CPU, APB programmed
// Assumes: Single pclk domain; partner keeps the link handshakes
// Notes:   Word memory 256 x 16, bytes packed low byte first
`timescale 1ns/1ns

// What this block does
// RQ1 - Module read copies bytes into word memory
// RQ2 - Module write sends bytes from word memory
// RQ3 - Stack level two: base, slot select module
// RQ4 - Stack level one: byte count, 128 max
// RQ5 - Accumulator gives module-side start address
// RQ6 - Operand gives word memory start location
// RQ7 - Bad parameters set shared error flag
// RQ8 - Flags hold until next command reuses them
// RQ9 - Network read fetches block from slave
// RQ10 - Read select: BCD slave, port or slot
// RQ11 - Network read: accumulator local, operand remote
// RQ12 - Network write select: slave, then F2
// RQ13 - Network write: accumulator gives local source
// RQ14 - Network write: operand gives slave destination
// RQ15 - Issue network transfers only when port idle
// RQ16 - Keep port busy and comm error current
// RQ17 - Two bytes per word, low first
module bte_engine
  import bte_pkg::*;
(
  bte_link_if.dev    link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_SEND, S_RECV, S_WAIT}
    bte_state_t;

  bte_state_t          state;
  logic [15:0]         mem [256];
  logic [15:0]         acc;
  logic [7:0]          stack1;
  logic [15:0]         stack2;
  logic [15:0]         operand;
  logic [1:0]          opcode;
  logic [7:0]          mem_addr;
  logic [7:0]          local_word;
  logic [7:0]          idx;
  logic                param_error_flag;
  logic                port_busy_flag;
  logic                port_comm_error_flag;
  logic [BTE_EV_W-1:0] event_bits;
  logic [BTE_EV_W-1:0] event_mask;
  logic [BTE_EV_W-1:0] event_seen;
  logic [BTE_EV_W-1:0] next_event_bits;
  logic                setup;
  logic                wr_acc;
  logic                rd_acc;
  logic                mapped;
  logic                go;
  logic                params_ok;
  logic                is_net;
  logic [15:0]         local_start;
  logic [7:0]          cur_word;
  logic                ev_done;
  logic                ev_perr;
  logic                ev_cerr;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign is_net = opcode[1];

  always_comb begin
    if (paddr == BTE_REG_CMD || paddr == BTE_REG_ACC ||
        paddr == BTE_REG_STACK1 || paddr == BTE_REG_STACK2 ||
        paddr == BTE_REG_OPERAND || paddr == BTE_REG_STATUS ||
        paddr == BTE_REG_EVENT || paddr == BTE_REG_MASK ||
        paddr == BTE_REG_MEMADDR || paddr == BTE_REG_MEMDATA)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end
  assign pslverr = psel && penable && !mapped;

  // Network: accumulator is local; module: operand is local
  always_comb begin
    if (pwdata[1])
      local_start = acc;                                  // [RQ11] [RQ13]
    else
      local_start = operand;                              // [RQ6]
  end

  bte_param_check u_check (
    .opcode     (pwdata[1:0]),
    .count      (stack1),
    .sel        (stack2),
    .local_addr (local_start),
    .params_ok  (params_ok)
  );

  assign go      = wr_acc && (paddr == BTE_REG_CMD) && (state == S_IDLE);
  assign ev_perr = go && !params_ok;
  assign ev_done = link.done && (state == S_SEND || state == S_RECV ||
                   state == S_WAIT);
  assign ev_cerr = ev_done && link.done_err;

  // Software parameter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc      <= 16'h0000;
      stack1   <= 8'h00;
      stack2   <= 16'h0000;
      operand  <= 16'h0000;
      mem_addr <= 8'h00;
      event_mask <= '0;
    end else if (wr_acc) begin
      if (paddr == BTE_REG_ACC)
        acc <= pwdata[15:0];
      else if (paddr == BTE_REG_STACK1)
        stack1 <= pwdata[7:0];                            // [RQ4]
      else if (paddr == BTE_REG_STACK2)
        stack2 <= pwdata[15:0];                           // [RQ3] [RQ10]
      else if (paddr == BTE_REG_OPERAND)
        operand <= pwdata[15:0];
      else if (paddr == BTE_REG_MEMADDR)
        mem_addr <= pwdata[7:0];
      else if (paddr == BTE_REG_MASK)
        event_mask <= pwdata[BTE_EV_W-1:0];
    end
  end

  // Transfer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= S_IDLE;
      opcode     <= BTE_OP_MOD_RD;
      local_word <= 8'h00;
      idx        <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (go && params_ok) begin
            opcode     <= pwdata[1:0];
            local_word <= local_start[7:0];
            idx        <= 8'h00;
            state      <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (link.cmd_ready) begin
            if (link.cmd_write)
              state <= S_SEND;                            // [RQ2]
            else
              state <= S_RECV;                            // [RQ1] [RQ9]
          end
        end
        S_SEND, S_RECV: begin
          if (link.done)
            state <= S_IDLE;
          else if ((state == S_SEND && link.tx_ready) ||
                   (state == S_RECV && link.rx_valid)) begin
            idx <= idx + 8'h01;
            if (idx + 8'h01 == stack1)
              state <= S_WAIT;                            // [RQ4]
          end
        end
        S_WAIT: begin
          if (link.done)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Link drive; module remote is accumulator, network remote is operand
  assign link.cmd_valid = (state == S_ISSUE);
  assign link.cmd_write = opcode[0];
  assign link.cmd_net   = is_net;
  assign link.cmd_sel   = stack2;                         // [RQ3]
  assign link.cmd_addr  = is_net ? operand : acc;         // [RQ11] [RQ14]
  assign link.cmd_count = stack1;
  assign cur_word       = local_word + {1'b0, idx[7:1]};  // [RQ17]
  assign link.tx_valid  = (state == S_SEND);
  assign link.tx_data   = idx[0] ? mem[cur_word][15:8]
                                 : mem[cur_word][7:0];    // [RQ17]
  assign link.rx_ready  = (state == S_RECV);

  // Word memory: link byte writes take priority over software
  always_ff @(posedge pclk) begin
    if (state == S_RECV && link.rx_valid && !link.done) begin
      if (idx[0])
        mem[cur_word][15:8] <= link.rx_data;              // [RQ1] [RQ17]
      else
        mem[cur_word][7:0] <= link.rx_data;               // [RQ17]
    end else if (wr_acc && paddr == BTE_REG_MEMDATA)
      mem[mem_addr] <= pwdata[15:0];
  end

  // Status flags, each overwritten by the next command using it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_error_flag     <= 1'b0;
      port_busy_flag       <= 1'b0;
      port_comm_error_flag <= 1'b0;
    end else begin
      if (go)
        param_error_flag <= !params_ok;                   // [RQ7] [RQ8]
      if (go && params_ok && pwdata[1]) begin
        port_busy_flag       <= 1'b1;                     // [RQ16] [RQ15]
        port_comm_error_flag <= 1'b0;                     // [RQ8]
      end else if (ev_done && is_net) begin
        port_busy_flag       <= 1'b0;                     // [RQ16]
        port_comm_error_flag <= link.done_err;            // [RQ16]
      end
    end
  end

  // Sticky events; a read clears only the bits it returned
  always_comb begin
    next_event_bits = event_bits;
    if (rd_acc && paddr == BTE_REG_EVENT)
      next_event_bits = event_bits & ~event_seen;
    next_event_bits = next_event_bits | {ev_cerr, ev_perr, ev_done};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_bits <= '0;
      irq        <= 1'b0;
    end else begin
      event_bits <= next_event_bits;
      irq        <= |(next_event_bits & event_mask);
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h00000000;
      event_seen <= '0;
    end else if (setup && !pwrite) begin
      event_seen <= '0;
      if (paddr == BTE_REG_CMD)
        prdata <= {30'h0, opcode};
      else if (paddr == BTE_REG_ACC)
        prdata <= {16'h0000, acc};
      else if (paddr == BTE_REG_STACK1)
        prdata <= {24'h000000, stack1};
      else if (paddr == BTE_REG_STACK2)
        prdata <= {16'h0000, stack2};
      else if (paddr == BTE_REG_OPERAND)
        prdata <= {16'h0000, operand};
      else if (paddr == BTE_REG_STATUS)
        prdata <= {28'h0000000, port_comm_error_flag, port_busy_flag,
                   param_error_flag, state != S_IDLE};    // [RQ16]
      else if (paddr == BTE_REG_EVENT) begin
        prdata     <= {29'h0, event_bits};
        event_seen <= event_bits;
      end else if (paddr == BTE_REG_MASK)
        prdata <= {29'h0, event_mask};
      else if (paddr == BTE_REG_MEMADDR)
        prdata <= {24'h000000, mem_addr};
      else if (paddr == BTE_REG_MEMDATA)
        prdata <= {16'h0000, mem[mem_addr]};
      else
        prdata <= 32'h00000000;
    end
  end
endmodule : bte_engine

/* bte_pkg.sv */
// Purpose: Shared constants for the block transfer engine and its partner
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Local word memory is 256 x 16; partner store is 256 bytes
package bte_pkg;

  // APB register offsets
  localparam logic [7:0] BTE_REG_CMD     = 8'h00;
  localparam logic [7:0] BTE_REG_ACC     = 8'h04;
  localparam logic [7:0] BTE_REG_STACK1  = 8'h08;
  localparam logic [7:0] BTE_REG_STACK2  = 8'h0c;
  localparam logic [7:0] BTE_REG_OPERAND = 8'h10;
  localparam logic [7:0] BTE_REG_STATUS  = 8'h14;
  localparam logic [7:0] BTE_REG_EVENT   = 8'h18;
  localparam logic [7:0] BTE_REG_MASK    = 8'h1c;
  localparam logic [7:0] BTE_REG_MEMADDR = 8'h20;
  localparam logic [7:0] BTE_REG_MEMDATA = 8'h24;

  // Command codes, CMD bits [1:0]
  localparam logic [1:0] BTE_OP_MOD_RD = 2'h0;
  localparam logic [1:0] BTE_OP_MOD_WR = 2'h1;
  localparam logic [1:0] BTE_OP_NET_RD = 2'h2;
  localparam logic [1:0] BTE_OP_NET_WR = 2'h3;

  // STATUS bit positions
  localparam int BTE_ST_BUSY      = 0;
  localparam int BTE_ST_PARAM_ERR = 1;
  localparam int BTE_ST_PORT_BUSY = 2;
  localparam int BTE_ST_COMM_ERR  = 3;

  // EVENT / MASK bit positions
  localparam int BTE_EV_DONE      = 0;
  localparam int BTE_EV_PARAM_ERR = 1;
  localparam int BTE_EV_COMM_ERR  = 2;
  localparam int BTE_EV_W         = 3;

  // Parameter limits
  localparam logic [7:0]  BTE_MAX_BYTES  = 8'h80;
  localparam logic [7:0]  BTE_MAX_BASE   = 8'h03;
  localparam logic [7:0]  BTE_MAX_SLOT   = 8'h07;
  localparam logic [7:0]  BTE_MAX_SLAVE  = 8'h90;
  localparam logic [7:0]  BTE_INT_PORT   = 8'hf2;
  localparam logic [8:0]  BTE_MEM_WORDS  = 9'h100;
  localparam logic [8:0]  BTE_FAR_BYTES  = 9'h100;

endpackage : bte_pkg

/* bte_link_if.sv */
// Purpose: Link between the transfer engine and the module or slave station
// Assumes: Both ends run on pclk
// Notes:   Command handshake, two byte streams, one done pulse
`timescale 1ns/1ns
interface bte_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic        cmd_net;
  logic [15:0] cmd_sel;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_count;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_ready;
  logic        done;
  logic        done_err;

  modport dev (
    input  pclk, presetn, cmd_ready, tx_ready, rx_valid, rx_data,
           done, done_err,
    output cmd_valid, cmd_write, cmd_net, cmd_sel, cmd_addr, cmd_count,
           tx_valid, tx_data, rx_ready
  );

  modport far (
    input  pclk, presetn, cmd_valid, cmd_write, cmd_net, cmd_sel,
           cmd_addr, cmd_count, tx_valid, tx_data, rx_ready,
    output cmd_ready, tx_ready, rx_valid, rx_data, done, done_err
  );
endinterface : bte_link_if

/* bte_param_check.sv */
// Purpose: Validates transfer parameters before a command starts
// Assumes: Pure combinational; opcode comes from pwdata, other inputs from the engine's registers
// Notes:   params_ok low raises the shared parameter error
`timescale 1ns/1ns
module bte_param_check
  import bte_pkg::*;
(
  input  wire logic [1:0]  opcode,
  input  wire logic [7:0]  count,
  input  wire logic [15:0] sel,
  input  wire logic [15:0] local_addr,
  output logic             params_ok
);
  logic       count_ok;
  logic       sel_ok;
  logic       mem_ok;
  logic       bcd_ok;
  logic [8:0] end_word;

  always_comb begin
    count_ok = (count != 8'h00) && (count <= BTE_MAX_BYTES);   // [RQ4]
    bcd_ok   = (sel[7:4] <= 4'h9) && (sel[3:0] <= 4'h9) &&
               (sel[7:0] <= BTE_MAX_SLAVE);                    // [RQ10]
    case (opcode)
      BTE_OP_MOD_RD,
      BTE_OP_MOD_WR: sel_ok = (sel[7:0] <= BTE_MAX_BASE) &&
                              (sel[15:8] <= BTE_MAX_SLOT);     // [RQ3]
      BTE_OP_NET_RD: sel_ok = bcd_ok && ((sel[15:8] == BTE_INT_PORT) ||
                              (sel[15:8] <= BTE_MAX_SLOT));    // [RQ10]
      default:       sel_ok = bcd_ok &&
                              (sel[15:8] == BTE_INT_PORT);     // [RQ12]
    endcase
    end_word  = {1'b0, local_addr[7:0]} + 9'({1'b0, count} + 9'h001 >> 1);
    mem_ok    = (local_addr[15:8] == 8'h00) && (end_word <= BTE_MEM_WORDS);
    params_ok = count_ok && sel_ok && mem_ok;                  // [RQ7]
  end
endmodule : bte_param_check

/* bte_far_end.sv */
// Purpose: Intelligent module or slave station answering the engine
// Assumes: Own 256-byte store, preloaded or read through the user port
// Notes:   Mismatched target or out-of-range address answers done_err
`timescale 1ns/1ns
module bte_far_end
  import bte_pkg::*;
(
  bte_link_if.far    link,
  input  wire logic [1:0] my_base,
  input  wire logic [2:0] my_slot,
  input  wire logic [7:0] my_station,
  input  wire logic [7:0] user_addr,
  input  wire logic [7:0] user_wdata,
  input  wire logic       user_we,
  output logic [7:0]      user_rdata
);
  typedef enum logic [1:0] {F_IDLE, F_SEND, F_RECV, F_DONE} bte_far_st_t;

  bte_far_st_t state;
  logic [7:0]  store [256];
  logic [7:0]  ptr;
  logic [7:0]  left;
  logic        err;
  logic        hit;
  logic [8:0]  end_byte;

  always_comb begin
    if (link.cmd_net)
      hit = (link.cmd_sel[7:0] == my_station);
    else
      hit = (link.cmd_sel[7:0] == {6'h00, my_base}) &&
            (link.cmd_sel[15:8] == {5'h00, my_slot});
    end_byte = 9'(link.cmd_addr[7:0]) + 9'(link.cmd_count);
  end

  assign link.cmd_ready = (state == F_IDLE);
  assign link.rx_valid  = (state == F_SEND);
  assign link.rx_data   = store[ptr];
  assign link.tx_ready  = (state == F_RECV);
  assign link.done      = (state == F_DONE);
  assign link.done_err  = err;

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state <= F_IDLE;
      ptr   <= 8'h00;
      left  <= 8'h00;
      err   <= 1'b0;
    end else begin
      case (state)
        F_IDLE: begin
          if (link.cmd_valid) begin
            ptr  <= link.cmd_addr[7:0];                       // [RQ5]
            left <= link.cmd_count;
            err  <= !hit || (link.cmd_addr[15:8] != 8'h00) ||
                    (end_byte > BTE_FAR_BYTES);
            if (!hit || (link.cmd_addr[15:8] != 8'h00) ||
                (end_byte > BTE_FAR_BYTES))
              state <= F_DONE;
            else if (link.cmd_write)
              state <= F_RECV;
            else
              state <= F_SEND;
          end
        end
        F_SEND: begin
          if (link.rx_ready) begin
            ptr  <= ptr + 8'h01;
            left <= left - 8'h01;
            if (left == 8'h01)
              state <= F_DONE;
          end
        end
        F_RECV: begin
          if (link.tx_valid) begin
            ptr  <= ptr + 8'h01;
            left <= left - 8'h01;
            if (left == 8'h01)
              state <= F_DONE;
          end
        end
        default: state <= F_IDLE;
      endcase
    end
  end

  always_ff @(posedge link.pclk) begin
    if (state == F_RECV && link.tx_valid)
      store[ptr] <= link.tx_data;
    else if (user_we)
      store[user_addr] <= user_wdata;
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn)
      user_rdata <= 8'h00;
    else
      user_rdata <= store[user_addr];
  end
endmodule : bte_far_end

/* bte_link_sva.sv */
// Purpose: Link protocol checks between engine and far end
// Assumes: One pclk domain, presetn async active low
// Notes:   Byte counter ties every handshake to cmd_count
`timescale 1ns/1ns
module bte_link_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        cmd_write,
  input wire logic        cmd_net,
  input wire logic [15:0] cmd_sel,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0]  cmd_count,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        done,
  input wire logic        done_err
);
  logic [7:0] n_bytes;
  logic       active;
  wire        cmd_fire  = cmd_valid && cmd_ready;
  wire        byte_fire = (tx_valid && tx_ready) || (rx_valid && rx_ready);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bytes moved since the last accepted command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) n_bytes <= 8'h00;
    else if (cmd_fire) n_bytes <= 8'h00;
    else if (byte_fire) n_bytes <= n_bytes + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) active <= 1'b0;
    else if (cmd_fire) active <= 1'b1;
    else if (done) active <= 1'b0;
  end

  AST_COUNT_RANGE: assert property (
    cmd_valid |-> cmd_count != 8'h00 && cmd_count <= 8'h80)
    else $error("command byte count out of range");
  AST_MOD_SEL: assert property (
    cmd_valid && !cmd_net |-> cmd_sel[7:0] <= 8'h03 && cmd_sel[15:8] <= 8'h07)
    else $error("module select out of range");
  AST_NET_RD_SEL: assert property (
    cmd_valid && cmd_net && !cmd_write |-> cmd_sel[3:0] <= 4'h9 &&
    cmd_sel[7:0] <= 8'h90 &&
    (cmd_sel[15:8] == 8'hf2 || cmd_sel[15:8] <= 8'h07))
    else $error("network read select malformed");
  AST_NET_WR_SEL: assert property (
    cmd_valid && cmd_net && cmd_write |-> cmd_sel[3:0] <= 4'h9 &&
    cmd_sel[7:0] <= 8'h90 && cmd_sel[15:8] == 8'hf2)
    else $error("network write select malformed");
  AST_CMD_STANDS: assert property (
    active |-> $stable(cmd_addr) && $stable(cmd_count) && $stable(cmd_write))
    else $error("command fields changed during transfer");
  AST_TX_DIR: assert property (
    tx_valid |-> cmd_write && !rx_ready)
    else $error("bytes sent on a read command");
  AST_RX_DIR: assert property (
    rx_ready |-> !cmd_write && !tx_valid)
    else $error("bytes taken on a write command");
  AST_BYTE_TOTAL: assert property (
    done && !done_err |-> n_bytes == cmd_count)
    else $error("byte total differs from count");
  AST_NO_EXTRA: assert property (
    byte_fire |-> active && n_bytes < cmd_count)
    else $error("byte moved beyond count");
  AST_ONE_CMD: assert property (
    active |-> !cmd_valid)
    else $error("second command while port occupied");
  AST_DONE_PULSE: assert property (
    done |=> !done && !active)
    else $error("done not a single pulse");
  AST_DONE_TIMELY: assert property (
    cmd_fire |-> ##[1:300] done)
    else $error("transfer never completed");
endmodule : bte_link_sva

/* tb.sv */
// Purpose: Self-checking bench for engine and far end joined by the link
// Assumes: Far end strapped as base 1, slot 2, station 05
// Notes:   Expected bytes are packed low byte first by hand
`timescale 1ns/1ns
module tb
  import bte_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        user_we, err, seen_pb;
  logic [7:0]  paddr, user_addr, user_wdata, user_rdata;
  logic [31:0] pwdata, prdata, q;
  int          mismatches, n_compared, cycles;

  bte_link_if i_bte_link_if (.pclk(pclk), .presetn(presetn));
  bte_engine i_bte_engine (.link(i_bte_link_if.dev), .pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  bte_far_end i_bte_far_end (.link(i_bte_link_if.far), .my_base(2'h1),
    .my_slot(3'h2), .my_station(8'h05), .user_addr(user_addr),
    .user_wdata(user_wdata), .user_we(user_we), .user_rdata(user_rdata));
  bte_link_sva i_bte_link_sva (.pclk(pclk), .presetn(presetn),
    .cmd_valid(i_bte_link_if.cmd_valid), .cmd_ready(i_bte_link_if.cmd_ready),
    .cmd_write(i_bte_link_if.cmd_write), .cmd_net(i_bte_link_if.cmd_net),
    .cmd_sel(i_bte_link_if.cmd_sel), .cmd_addr(i_bte_link_if.cmd_addr),
    .cmd_count(i_bte_link_if.cmd_count), .tx_valid(i_bte_link_if.tx_valid),
    .tx_ready(i_bte_link_if.tx_ready), .rx_valid(i_bte_link_if.rx_valid),
    .rx_ready(i_bte_link_if.rx_ready), .done(i_bte_link_if.done),
    .done_err(i_bte_link_if.done_err));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic mem_chk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b1, BTE_REG_MEMADDR, {24'h0, a});
    apb(1'b0, BTE_REG_MEMDATA, 32'h0);
    chk("word memory", {16'h0, e}, q);
  endtask : mem_chk

  task automatic mem_wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, BTE_REG_MEMADDR, {24'h0, a});
    apb(1'b1, BTE_REG_MEMDATA, {16'h0, d});
  endtask : mem_wr

  // Program the command registers, then poll until idle
  task automatic go(input logic [1:0] op, input logic [15:0] acc,
                    input logic [15:0] cnt, input logic [15:0] sel,
                    input logic [15:0] opnd);
    apb(1'b1, BTE_REG_ACC, {16'h0, acc});
    apb(1'b1, BTE_REG_STACK1, {16'h0, cnt});
    apb(1'b1, BTE_REG_STACK2, {16'h0, sel});
    apb(1'b1, BTE_REG_OPERAND, {16'h0, opnd});
    apb(1'b1, BTE_REG_CMD, {30'h0, op});
    seen_pb = 1'b0;
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, BTE_REG_STATUS, 32'h0);
      if (q[BTE_ST_PORT_BUSY] === 1'b1) seen_pb = 1'b1;
      if (q[BTE_ST_BUSY] === 1'b0) break;
    end
    chk("engine idle", 32'h0, {31'h0, q[BTE_ST_BUSY]});
  endtask : go

  task automatic far_poke(input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    user_addr  <= a;
    user_wdata <= d;
    user_we    <= 1'b1;
    @(posedge pclk);
    user_we    <= 1'b0;
  endtask : far_poke

  task automatic far_peek(input logic [7:0] a, input logic [7:0] e);
    @(posedge pclk);
    user_addr <= a;
    repeat (2) @(posedge pclk);
    #1;
    chk("far store", {24'h0, e}, {24'h0, user_rdata});
  endtask : far_peek

  task automatic t_regs();
    apb(1'b0, BTE_REG_STATUS, 32'h0);
    chk("status reset", 32'h0, q);
    apb(1'b0, BTE_REG_MASK, 32'h0);
    chk("mask reset", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
    $display("test regs done");
  endtask : t_regs

  task automatic t_param();
    logic [1:0]  op_t[7]  = '{BTE_OP_MOD_RD, BTE_OP_MOD_WR, BTE_OP_MOD_RD,
                              BTE_OP_MOD_WR, BTE_OP_NET_WR, BTE_OP_NET_RD,
                              BTE_OP_MOD_RD};
    logic [15:0] cnt_t[7] = '{16'h0, 16'h81, 16'h2, 16'h2, 16'h2, 16'h2,
                              16'h4};
    logic [15:0] sel_t[7] = '{16'h0201, 16'h0201, 16'h0204, 16'h0801,
                              16'h0105, 16'hf291, 16'h0201};
    for (int i = 0; i < 7; i++) begin
      go(op_t[i], 16'h0010, cnt_t[i], sel_t[i],
         (i == 6) ? 16'h00ff : 16'h0010);
      chk("param error", 32'h1, {31'h0, q[BTE_ST_PARAM_ERR]});
    end
    go(BTE_OP_MOD_RD, 16'h0000, 16'h0080, 16'h0201, 16'h0080);
    chk("param error", 32'h0, {31'h0, q[BTE_ST_PARAM_ERR]});
    apb(1'b0, BTE_REG_EVENT, 32'h0);
    chk("event", 32'h3, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test param done");
  endtask : t_param

  task automatic t_mod_wr();
    apb(1'b1, BTE_REG_MASK, 32'h1);
    mem_wr(8'h10, 16'h2211);
    mem_wr(8'h11, 16'h4433);
    far_poke(8'h23, 8'h77);
    go(BTE_OP_MOD_WR, 16'h0020, 16'h0003, 16'h0201, 16'h0010);
    far_peek(8'h20, 8'h11);
    far_peek(8'h21, 8'h22);
    far_peek(8'h22, 8'h33);
    far_peek(8'h23, 8'h77);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, BTE_REG_EVENT, 32'h0);
    chk("event", 32'h1, q);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test module write done");
  endtask : t_mod_wr

  task automatic t_mod_rd();
    far_poke(8'h40, 8'h5a);
    far_poke(8'h41, 8'ha5);
    far_poke(8'h42, 8'hc3);
    go(BTE_OP_MOD_RD, 16'h0040, 16'h0003, 16'h0201, 16'h0030);
    mem_chk(8'h30, 16'ha55a);
    apb(1'b1, BTE_REG_MEMADDR, 32'h31);
    apb(1'b0, BTE_REG_MEMDATA, 32'h0);
    chk("odd byte", 32'hc3, {24'h0, q[7:0]});
    $display("test module read done");
  endtask : t_mod_rd

  task automatic t_net();
    go(BTE_OP_NET_RD, 16'h0060, 16'h0002, 16'hf206, 16'h0000);
    chk("comm error", 32'h1, {31'h0, q[BTE_ST_COMM_ERR]});
    apb(1'b0, BTE_REG_EVENT, 32'h0);
    chk("comm event", 32'h1, {31'h0, q[BTE_EV_COMM_ERR]});
    go(BTE_OP_NET_WR, 16'h0010, 16'h0004, 16'hf205, 16'h0080);
    chk("port busy seen", 32'h1, {31'h0, seen_pb});
    chk("port idle", 32'h0, {31'h0, q[BTE_ST_PORT_BUSY]});
    chk("comm error", 32'h0, {31'h0, q[BTE_ST_COMM_ERR]});
    far_peek(8'h80, 8'h11);
    far_peek(8'h83, 8'h44);
    go(BTE_OP_NET_RD, 16'h0050, 16'h0004, 16'hf205, 16'h0080);
    mem_chk(8'h50, 16'h2211);
    mem_chk(8'h51, 16'h4433);
    $display("test network done");
  endtask : t_net

  initial begin
    {psel, penable, pwrite, user_we} = 4'h0;
    {paddr, user_addr, user_wdata} = 24'h0;
    pwdata = 32'h0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_param();
    t_mod_wr();
    t_mod_rd();
    t_net();
    summarize();
  end
endmodule : tb
